// File: rtl/arith_insn_decode_timing.sv
// Purpose: Decodes arithmetic instructions and paces them by their clock cost
// Assumes: AXI4-Lite slave, 32-bit data, sys_clk 250 MHz, srst synchronous
// Notes: Software writes opcode and mod/reg/r/m bytes, then reads the result
// Function
// (RULE1) Add register/memory form costs 2 or 7
// (RULE2) Carry add opcodes, reg 010, accumulator 3
// (RULE3) Subtract opcodes, immediate reg 101, 3/7
// (RULE4) Borrow subtract opcodes, reg 011, accumulator 3
// (RULE5) ASCII sum fixup 37h, 3 clocks
// (RULE6) BCD sum fixup 27h, 3 clocks
// (RULE7) ASCII difference fixup 3Fh, 3 clocks
// (RULE8) BCD difference fixup 2Fh, 3 clocks
// (RULE9) Unsigned product reg 100: 13/21/16/24
// (RULE10) Signed product reg 101: 13/21/16/24
// (RULE11) Second immediate byte only for word, unsigned
// (RULE12) w selects word; d=1 makes reg destination
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "arith_decode_map.svh"
module arith_insn_decode_timing
    import arith_decode_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam logic [1:0] RESP_OKAY = 2'h0; // Normal answer
    localparam logic [1:0] RESP_SLVERR = 2'h2; // Unmapped address

    // Decode one instruction from opcode and mod/reg/r/m byte
    function automatic decode_t decode_insn(input logic [7:0] op, input logic [7:0] mrm);
        decode_t d;
        logic has_mrm;
        logic [1:0] disp;
        logic [1:0] imm;
        d = '0;
        has_mrm = 1'b1;
        disp = 2'h0;
        imm = 2'h0;
        d.cls = cls_none;
        d.word = op[0]; // RULE12
        casez (op)
            `OPC_ADD_RM: d.cls = add_rm; // RULE1
            `OPC_ADC_RM: d.cls = adc_rm; // RULE2
            `OPC_SUB_RM: d.cls = sub_rm; // RULE3
            `OPC_SBB_RM: d.cls = borrow_difference_op_rm; // RULE4
            `OPC_ADD_ACC: d.cls = add_acc;
            `OPC_ADC_ACC: d.cls = adc_acc; // RULE2
            `OPC_SUB_ACC: d.cls = sub_acc;
            `OPC_SBB_ACC: d.cls = borrow_difference_op_acc; // RULE4
            `OPC_ASCII_SUM: d.cls = ascii_sum_fixup; // RULE5
            `OPC_BCD_SUM: d.cls = bcd_sum_fixup; // RULE6
            `OPC_ASCII_DIFF: d.cls = ascii_difference_fixup; // RULE7
            `OPC_BCD_DIFF: d.cls = bcd_difference_fixup; // RULE8
            `OPC_IMM_GRP: begin
                // Reg field picks the operation
                case (mrm[5:3])
                    `REG_ADD: d.cls = add_imm;
                    `REG_ADC: d.cls = adc_imm; // RULE2
                    `REG_SUB: d.cls = sub_imm; // RULE3
                    `REG_SBB: d.cls = borrow_difference_op_imm; // RULE4
                    default: d.cls = cls_none;
                endcase
            end
            `OPC_PROD_GRP: begin
                if (mrm[5:3] == `REG_UPROD) begin
                    d.cls = unsigned_product_op; // RULE9
                end else if (mrm[5:3] == `REG_SPROD) begin
                    d.cls = signed_product_op; // RULE10
                end else begin
                    d.cls = cls_none;
                end
            end
            default: d.cls = cls_none;
        endcase
        // Per-class operand shape
        case (d.cls)
            add_rm, adc_rm, sub_rm, borrow_difference_op_rm: begin
                d.dir = op[1]; // RULE12
            end
            add_imm, adc_imm, sub_imm, borrow_difference_op_imm: begin
                // s:w = 01 alone brings a second byte
                imm = (op[1:0] == 2'b01) ? 2'h2 : 2'h1; // RULE11
            end
            add_acc, adc_acc, sub_acc, borrow_difference_op_acc: begin
                has_mrm = 1'b0;
                imm = op[0] ? 2'h2 : 2'h1; // RULE11
            end
            unsigned_product_op, signed_product_op: begin
                d.dir = 1'b0;
            end
            default: begin
                // Single-byte fixups and unknown opcodes
                has_mrm = 1'b0;
                d.word = 1'b0;
            end
        endcase
        // Displacement and memory operand from mod and r/m
        if (has_mrm) begin
            d.mem = (mrm[7:6] != 2'b11);
            case (mrm[7:6])
                2'b00: disp = (mrm[2:0] == 3'b110) ? 2'h2 : 2'h0;
                2'b01: disp = 2'h1;
                2'b10: disp = 2'h2;
                default: disp = 2'h0;
            endcase
        end
        d.len = 3'h1 + {2'h0, has_mrm} + {1'b0, disp} + {1'b0, imm};
        // Cost table address
        case (d.cls)
            add_rm, adc_rm, sub_rm, borrow_difference_op_rm:
                d.cost_idx = d.mem ? `CIDX_ALU_MEM : `CIDX_ALU_REG; // RULE1
            add_imm, adc_imm, sub_imm, borrow_difference_op_imm:
                d.cost_idx = d.mem ? `CIDX_IMM_MEM : `CIDX_IMM_REG; // RULE3
            add_acc, adc_acc, sub_acc, borrow_difference_op_acc, ascii_sum_fixup,
            bcd_sum_fixup, ascii_difference_fixup, bcd_difference_fixup:
                d.cost_idx = `CIDX_SHORT; // RULE5
            unsigned_product_op, signed_product_op: begin
                case ({d.mem, d.word})
                    2'b00: d.cost_idx = `CIDX_PROD_RB; // RULE9
                    2'b01: d.cost_idx = `CIDX_PROD_RW; // RULE10
                    2'b10: d.cost_idx = `CIDX_PROD_MB;
                    default: d.cost_idx = `CIDX_PROD_MW;
                endcase
            end
            default: d.cost_idx = `CIDX_NONE;
        endcase
        return d;
    endfunction

    logic [31:0] insn_reg, insn_next; // Instruction bytes under test
    logic pmode_reg, pmode_next; // Protected mode select
    logic done_reg, done_next; // Sticky: execution finished
    logic refused_reg, refused_next; // Sticky: write while busy
    logic illegal_reg, illegal_next; // Last opcode not in this group
    seq_state_t state_reg, state_next; // Sequencer
    logic [4:0] cnt_reg, cnt_next; // Remaining execution clocks
    logic [4:0] cost_reg, cost_next; // Cost of last instruction
    logic aw_full_reg, aw_full_next; // Address held
    logic w_full_reg, w_full_next; // Data held
    logic [3:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic awready_next, wready_next, bvalid_next, arready_next, rvalid_next;
    logic [1:0] bresp_next, rresp_next;
    logic [31:0] rdata_next;
    decode_t dec; // Decode of insn_reg
    logic [4:0] rom_data; // Registered cost lookup
    logic do_write; // Both halves of a write present
    logic insn_wr; // Write to instruction register
    logic busy; // Sequencer not idle

    assign dec = decode_insn(insn_reg[7:0], insn_reg[15:8]);
    assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign insn_wr = do_write && (awaddr_reg == `OFS_INSN);
    assign busy = (state_reg != st_idle);

    // Cost table
    cost_rom u_cost_rom (
        .sys_clk(sys_clk),
        .srst(srst),
        .addr(dec.cost_idx),
        .rd_data(rom_data)
    );

    // Bus channel next values
    always_comb begin
        aw_full_next = aw_full_reg;
        w_full_next = w_full_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = s_axi_bvalid;
        bresp_next = s_axi_bresp;
        rvalid_next = s_axi_rvalid;
        rresp_next = s_axi_rresp;
        rdata_next = s_axi_rdata;
        // Address and data accepted in either order
        if (s_axi_awvalid && s_axi_awready) begin
            aw_full_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_full_next = 1'b1;
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
        end
        if (do_write) begin
            aw_full_next = 1'b0;
            w_full_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = (awaddr_reg[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        // Read answers one cycle after the address
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            case (s_axi_araddr)
                `OFS_INSN: rdata_next = insn_reg;
                `OFS_CTRL: rdata_next = {31'h0, pmode_reg};
                `OFS_STATUS: rdata_next = {28'h0, illegal_reg, refused_reg, done_reg, busy};
                `OFS_RESULT: begin
                    rdata_next = 32'h0;
                    rdata_next[`RES_COST_LSB +: 5] = cost_reg;
                    rdata_next[`RES_LEN_LSB +: 3] = dec.len;
                    rdata_next[`RES_CLS_LSB +: 5] = dec.cls;
                    rdata_next[`RES_MEM_BIT] = dec.mem;
                    rdata_next[`RES_WORD_BIT] = dec.word;
                    rdata_next[`RES_DEST_BIT] = dec.dir;
                    rdata_next[`RES_PMODE_BIT] = pmode_reg;
                end
                default: begin
                    rdata_next = 32'h0;
                    rresp_next = RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        awready_next = !aw_full_next;
        wready_next = !w_full_next;
        arready_next = !rvalid_next;
    end

    // Register file and sequencer next values
    always_comb begin
        insn_next = insn_reg;
        pmode_next = pmode_reg;
        done_next = done_reg;
        refused_next = refused_reg;
        illegal_next = illegal_reg;
        state_next = state_reg;
        cnt_next = cnt_reg;
        cost_next = cost_reg;
        // Done and refused clear by writing one, before any set below
        if (do_write && awaddr_reg == `OFS_STATUS && wstrb_reg[0]) begin
            done_next = done_reg && !wdata_reg[`ST_DONE_BIT];
            refused_next = refused_reg && !wdata_reg[`ST_REFUSED_BIT];
        end
        if (do_write && awaddr_reg == `OFS_CTRL && wstrb_reg[0]) begin
            pmode_next = wdata_reg[0];
        end
        case (state_reg)
            st_idle: begin
                // New instruction starts decoding
                if (insn_wr) begin
                    for (int i = 0; i < 4; i++) begin
                        if (wstrb_reg[i]) begin
                            insn_next[8*i +: 8] = wdata_reg[8*i +: 8];
                        end
                    end
                    state_next = st_decode;
                end
            end
            st_decode: begin
                // Cost lookup is registered this cycle
                state_next = st_exec;
            end
            st_exec: begin
                if (cnt_reg == 5'h0) begin
                    // First exec cycle loads the cost
                    cost_next = rom_data;
                    cnt_next = rom_data;
                    illegal_next = (rom_data == `COST_NONE);
                    if (rom_data <= 5'h1) begin
                        state_next = st_idle;
                        done_next = 1'b1;
                        cnt_next = 5'h0;
                    end
                end else if (cnt_reg == 5'h2) begin
                    state_next = st_idle;
                    done_next = 1'b1;
                    cnt_next = 5'h0;
                end else begin
                    cnt_next = cnt_reg - 5'h1;
                end
            end
            default: state_next = st_idle;
        endcase
        // Instruction writes while busy are dropped and flagged
        if (insn_wr && busy) begin
            refused_next = 1'b1;
        end
    end

    // All state registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            insn_reg <= `INSN_RESET;
            pmode_reg <= `CTRL_RESET;
            done_reg <= 1'b0;
            refused_reg <= 1'b0;
            illegal_reg <= 1'b0;
            state_reg <= st_idle;
            cnt_reg <= 5'h0;
            cost_reg <= 5'h0;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awaddr_reg <= 4'h0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h0;
        end else begin
            insn_reg <= insn_next;
            pmode_reg <= pmode_next;
            done_reg <= done_next;
            refused_reg <= refused_next;
            illegal_reg <= illegal_next;
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            cost_reg <= cost_next;
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            s_axi_awready <= awready_next;
            s_axi_wready <= wready_next;
            s_axi_bvalid <= bvalid_next;
            s_axi_bresp <= bresp_next;
            s_axi_arready <= arready_next;
            s_axi_rvalid <= rvalid_next;
            s_axi_rresp <= rresp_next;
            s_axi_rdata <= rdata_next;
        end
    end

    // Checks on decode and pacing
    AST_ADD_REG_COST: assert property (@(posedge sys_clk) disable iff (srst) // RULE1
        (state_reg == st_decode && dec.cls == add_rm && !dec.mem) |=> (rom_data == 5'h02))
        else $error("add register form cost not 2");
    AST_ADC_ACC_FORM: assert property (@(posedge sys_clk) disable iff (srst) // RULE2
        (insn_reg[7:1] == 7'h0A) |-> (dec.cls == adc_acc && dec.len == 3'h2 + {2'h0, insn_reg[0]}))
        else $error("carry add accumulator form misdecoded");
    AST_SUB_IMM_MEM: assert property (@(posedge sys_clk) disable iff (srst) // RULE3
        (state_reg == st_decode && dec.cls == sub_imm && dec.mem) |=> ##1 (cnt_reg == 5'h07))
        else $error("subtract immediate memory cost not 7");
    AST_SBB_IMM_SEL: assert property (@(posedge sys_clk) disable iff (srst) // RULE4
        (insn_reg[7:2] == 6'h20 && insn_reg[13:11] == 3'h3)
        |-> (dec.cls == borrow_difference_op_imm))
        else $error("borrow subtract immediate not selected by reg 011");
    AST_ASCII_SUM: assert property (@(posedge sys_clk) disable iff (srst) // RULE5
        (state_reg == st_decode && insn_reg[7:0] == 8'h37) |=> ##1 (cnt_reg == 5'h03 && dec.len == 3'h1))
        else $error("ascii sum fixup not 3 clocks single byte");
    AST_BCD_DIFF: assert property (@(posedge sys_clk) disable iff (srst) // RULE8
        (state_reg == st_decode && insn_reg[7:0] == 8'h2F) |=> (rom_data == 5'h03))
        else $error("bcd difference fixup cost not 3");
    AST_UPROD_MW: assert property (@(posedge sys_clk) disable iff (srst) // RULE9
        (state_reg == st_decode && dec.cls == unsigned_product_op && dec.mem && dec.word)
        |=> (rom_data == 5'h18))
        else $error("unsigned word memory product cost not 24");
    AST_SPROD_RB: assert property (@(posedge sys_clk) disable iff (srst) // RULE10
        (state_reg == st_decode && dec.cls == signed_product_op && !dec.mem && !dec.word)
        |=> (rom_data == 5'h0D))
        else $error("signed byte register product cost not 13");
    AST_IMM_LEN: assert property (@(posedge sys_clk) disable iff (srst) // RULE11
        (dec.cls == add_imm && insn_reg[15:14] == 2'b11)
        |-> (dec.len == ((insn_reg[1:0] == 2'b01) ? 3'h4 : 3'h3)))
        else $error("immediate byte count wrong");
    AST_DIR_WORD: assert property (@(posedge sys_clk) disable iff (srst) // RULE12
        (dec.cls == sub_rm) |-> (dec.dir == insn_reg[1] && dec.word == insn_reg[0]))
        else $error("direction or size flag misdecoded");
    AST_EXEC_END: assert property (@(posedge sys_clk) disable iff (srst)
        (state_reg == st_exec && cnt_reg == 5'h2) |=> (state_reg == st_idle && done_reg))
        else $error("execution did not end with done");
endmodule // arith_insn_decode_timing

// File: rtl/arith_decode_map.svh
// Purpose: Offsets, field positions, encodings and cycle costs of the decoder
// Assumes: 32-bit AXI4-Lite register window, one aligned word per register
// Notes: Costs are processor clocks; real and protected modes cost the same
`ifndef ARITH_DECODE_MAP_SVH
`define ARITH_DECODE_MAP_SVH

// Register byte offsets
`define OFS_INSN 4'h0
`define OFS_CTRL 4'h4
`define OFS_STATUS 4'h8
`define OFS_RESULT 4'hC

// Status bits
`define ST_BUSY_BIT 0
`define ST_DONE_BIT 1
`define ST_REFUSED_BIT 2
`define ST_ILLEGAL_BIT 3

// Result fields
`define RES_COST_LSB 0
`define RES_LEN_LSB 8
`define RES_CLS_LSB 12
`define RES_MEM_BIT 17
`define RES_WORD_BIT 18
`define RES_DEST_BIT 19
`define RES_PMODE_BIT 20

// Reset values
`define CTRL_RESET 1'h0
`define INSN_RESET 32'h0000_0000

// Opcode patterns
`define OPC_ADD_RM 8'b0000_00??
`define OPC_ADD_ACC 8'b0000_010?
`define OPC_ADC_RM 8'b0001_00??
`define OPC_ADC_ACC 8'b0001_010?
`define OPC_SUB_RM 8'b0010_10??
`define OPC_SUB_ACC 8'b0010_110?
`define OPC_SBB_RM 8'b0001_10??
`define OPC_SBB_ACC 8'b0001_110?
`define OPC_IMM_GRP 8'b1000_00??
`define OPC_PROD_GRP 8'b1111_011?
`define OPC_ASCII_SUM 8'h37
`define OPC_BCD_SUM 8'h27
`define OPC_ASCII_DIFF 8'h3F
`define OPC_BCD_DIFF 8'h2F

// Reg field selectors
`define REG_ADD 3'h0
`define REG_ADC 3'h2
`define REG_SBB 3'h3
`define REG_UPROD 3'h4
`define REG_SUB 3'h5
`define REG_SPROD 3'h5

// Cost table addresses
`define CIDX_NONE 4'h0
`define CIDX_ALU_REG 4'h1
`define CIDX_ALU_MEM 4'h2
`define CIDX_IMM_REG 4'h3
`define CIDX_IMM_MEM 4'h4
`define CIDX_SHORT 4'h5
`define CIDX_PROD_RB 4'h6
`define CIDX_PROD_RW 4'h7
`define CIDX_PROD_MB 4'h8
`define CIDX_PROD_MW 4'h9

// Costs in clocks
`define COST_NONE 5'h00
`define COST_ALU_REG 5'h02
`define COST_ALU_MEM 5'h07
`define COST_IMM_REG 5'h03
`define COST_IMM_MEM 5'h07
`define COST_SHORT 5'h03
`define COST_PROD_RB 5'h0D
`define COST_PROD_RW 5'h15
`define COST_PROD_MB 5'h10
`define COST_PROD_MW 5'h18

`endif

// File: rtl/arith_decode_pkg.sv
// Purpose: Types shared by the arithmetic decoder files
// Assumes: Constants come from arith_decode_map.svh
// Notes: Enum codes left to the tool
package arith_decode_pkg;

    // Decoded instruction form
    typedef enum logic [4:0] {
        cls_none, add_rm, add_imm, add_acc, adc_rm, adc_imm, adc_acc,
        sub_rm, sub_imm, sub_acc,
        borrow_difference_op_rm, borrow_difference_op_imm, borrow_difference_op_acc,
        ascii_sum_fixup, bcd_sum_fixup, ascii_difference_fixup, bcd_difference_fixup,
        unsigned_product_op, signed_product_op
    } insn_class_t;

    // Everything the decoder learns about one instruction
    typedef struct packed {
        insn_class_t cls;
        logic [2:0] len;
        logic mem;
        logic word;
        logic dir;
        logic [3:0] cost_idx;
    } decode_t;

    // Sequencer states
    typedef enum logic [1:0] {st_idle, st_decode, st_exec} seq_state_t;

endpackage

// File: rtl/cost_rom.sv
// Purpose: Clock cost lookup per instruction form, registered read
// Assumes: Address is a cost index from the map header
// Notes: Unused addresses read zero cost
`timescale 1ns/1ps
`include "arith_decode_map.svh"
module cost_rom (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [3:0] addr,
    output logic [4:0] rd_data
);
    logic [4:0] rd_data_next; // Table value for addr

    // Constant table
    always_comb begin
        case (addr)
            `CIDX_ALU_REG: rd_data_next = `COST_ALU_REG;
            `CIDX_ALU_MEM: rd_data_next = `COST_ALU_MEM;
            `CIDX_IMM_REG: rd_data_next = `COST_IMM_REG;
            `CIDX_IMM_MEM: rd_data_next = `COST_IMM_MEM;
            `CIDX_SHORT: rd_data_next = `COST_SHORT;
            `CIDX_PROD_RB: rd_data_next = `COST_PROD_RB;
            `CIDX_PROD_RW: rd_data_next = `COST_PROD_RW;
            `CIDX_PROD_MB: rd_data_next = `COST_PROD_MB;
            `CIDX_PROD_MW: rd_data_next = `COST_PROD_MW;
            default: rd_data_next = `COST_NONE;
        endcase
    end

    // Registered read port
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rd_data <= `COST_NONE;
        end else begin
            rd_data <= rd_data_next;
        end
    end
endmodule // cost_rom

// File: verification/testbench.sv
// Purpose: Self-checking bench for the arithmetic decoder over AXI4-Lite
// Assumes: Answer timing as handed over; bready and rready held high throughout
// Notes: Random forms from a fixed seed, corner encodings first
`timescale 1ns/1ps
`define CHK(g, x) begin checks++; if ((g) !== (x)) begin err_count++; \
    $display("[ERR] %0t got %h expected %h", $time, (g), (x)); end end
module testbench;
    import arith_decode_pkg::*;
    logic sys_clk = 1'b0, srst = 1'b1, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, st, res, r;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, il;
    logic [1:0] s_axi_bresp, s_axi_rresp, rp;
    logic [20:0] e, m;
    logic [15:0] i;
    logic [15:0] corner [14] = '{16'h0037, 16'h0027, 16'h003F, 16'h002F, 16'hE8F7,
        16'h26F6, 16'h0681, 16'hD883, 16'hF0F6, 16'h8003, 16'hE8F6, 16'hC000, 16'h0015,
        16'hC02B};
    logic [2:0] grp [4] = '{3'h0, 3'h2, 3'h3, 3'h5};
    logic [7:0] fix [4] = '{8'h37, 8'h27, 8'h3F, 8'h2F};
    int err_count = 0, checks = 0, seed = 13508;

    arith_insn_decode_timing i_dut (.sys_clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    // 250 MHz clock
    initial forever #2 sys_clk = ~sys_clk;

    task automatic tally_and_finish();
        if (err_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Handshakes judged from values settled before the edge
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic aw, w, b;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            @(negedge sys_clk);
            aw = s_axi_awvalid & s_axi_awready;
            w = s_axi_wvalid & s_axi_wready;
            b = s_axi_bvalid;
            rp = s_axi_bresp;
            @(posedge sys_clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) return;
        end
        err_count++;
        tally_and_finish();
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        logic ar, v;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            @(negedge sys_clk);
            ar = s_axi_arvalid & s_axi_arready;
            v = s_axi_rvalid;
            d = s_axi_rdata;
            rp = s_axi_rresp;
            @(posedge sys_clk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (v) return;
        end
        err_count++;
        tally_and_finish();
    endtask

    // Expected result word and the fields that apply to this form
    function automatic void predict(input logic [15:0] x, input logic pm);
        logic [7:0] op;
        logic [2:0] g, t, dsp, len;
        logic mem, ok;
        logic [4:0] cls, cost, base;
        op = x[7:0];
        g = x[13:11];
        mem = x[15:14] != 2'b11;
        dsp = (x[15:14] == 2'b10 || (x[15:14] == 2'b00 && x[10:8] == 3'h6)) ? 3'h2
            : {2'b00, x[15:14] == 2'b01};
        t = (op[7:2] == 6'b100000) ? g : op[5:3];
        ok = t == 3'h0 || t == 3'h2 || t == 3'h3 || t == 3'h5;
        base = t == 3'h0 ? add_rm : t == 3'h2 ? adc_rm : t == 3'h3 ? borrow_difference_op_rm
            : sub_rm;
        {cls, cost, len} = '0;
        m = 21'h11F01F;
        if (op[7:6] == 2'b00 && !op[2] && ok) begin
            cls = base;
            cost = mem ? 5'h07 : 5'h02;
            len = 3'h2 + dsp;
            m |= 21'h0E0700;
        end else if (op[7:6] == 2'b00 && op[2:1] == 2'b10 && ok) begin
            cls = base + 5'h02;
            cost = 5'h03;
            len = 3'h2 + op[0];
            m |= 21'h040700;
        end else if (op[7:2] == 6'b100000 && ok) begin
            cls = base + 5'h01;
            cost = mem ? 5'h07 : 5'h03;
            len = 3'h3 + dsp + (op[1:0] == 2'b01);
            m |= 21'h060700;
        end else if (op[7:1] == 7'b1111011 && (g == 3'h4 || g == 3'h5)) begin
            cls = g[0] ? signed_product_op : unsigned_product_op;
            cost = op[0] ? (mem ? 5'h18 : 5'h15) : (mem ? 5'h10 : 5'h0D);
            len = 3'h2 + dsp;
            m |= 21'h060700;
        end else if (op inside {8'h37, 8'h27, 8'h3F, 8'h2F}) begin
            cls = op == 8'h37 ? ascii_sum_fixup : op == 8'h27 ? bcd_sum_fixup
                : op == 8'h3F ? ascii_difference_fixup : bcd_difference_fixup;
            cost = 5'h03;
            len = 3'h1;
            m |= 21'h000700;
        end
        il = cls == cls_none;
        e = {pm, op[1], op[0], mem, cls, 1'b0, len, 3'b000, cost};
    endfunction

    // Decode one form, optionally retry while busy, then check the outcome
    task automatic run(input logic [15:0] x, input logic pm, input logic dbl);
        wr(4'h4, {31'h0, pm});
        wr(4'h0, {16'h0000, x});
        `CHK(rp, 2'b00)
        if (dbl) wr(4'h0, 32'h0000_0037);
        rd(4'h8, st);
        `CHK(st[1:0], 2'b01)
        for (int n = 0; n < 40 && !st[1]; n++) rd(4'h8, st);
        if (!st[1]) begin
            err_count++;
            tally_and_finish();
        end
        predict(x, pm);
        `CHK(st[3], il)
        `CHK(st[2], dbl)
        rd(4'hC, res);
        `CHK(res[20:0] & m, e & m)
        wr(4'h8, 32'h0000_0006);
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        rd(4'h4, st);
        `CHK(st, 32'h0000_0000)
        rd(4'h8, st);
        `CHK(st, 32'h0000_0000)
        rd(4'h1, st);
        `CHK({rp, st}, {2'b10, 32'h0000_0000})
        wr(4'h2, 32'h0000_0000);
        `CHK(rp, 2'b10)
        foreach (corner[k]) run(corner[k], k[0], k == 4);
        repeat (80) begin
            r = $random(seed);
            case (r[2:0])
                3'h0: i = {r[23:16], 2'b00, grp[r[9:8]], 1'b0, r[11:10]};
                3'h1: i = {r[23:16], 2'b00, grp[r[9:8]], 2'b10, r[10]};
                3'h2: i = {r[23:22], grp[r[9:8]], r[18:16], 6'b100000, r[11:10]};
                3'h3: i = {8'h00, fix[r[9:8]]};
                3'h4: i = {r[23:22], 2'b10, r[20], r[18:16], 7'b1111011, r[10]};
                default: i = r[23:8];
            endcase
            run(i, r[31], r[2:0] == 3'h4 && r[30]);
        end
        tally_and_finish();
    end
endmodule // testbench
